// >>> hw/pscp_pkg.sv
// shared constants for the parity and status-pin command block
package pscp_pkg;

    // clock and status-pin idle delay
    localparam int unsigned CLK_HZ       = 20_000_000;               // system clock rate
    localparam int unsigned IDLE_MS      = 1500;                     // quiet time before pin returns high
    localparam int unsigned IDLE_CYCLES  = IDLE_MS * (CLK_HZ / 1000); // 30,000,000 cycles
    localparam int unsigned IDLE_TW      = 25;                       // idle counter width

    // line and reply buffer sizing
    localparam int unsigned LINE_BYTES   = 14;                       // longest accepted command
    localparam int unsigned LEN_W        = 4;                        // line length counter width
    localparam int unsigned MSG_BYTES    = 16;                       // reply shift register depth

    // register byte offsets on the avalon slave
    localparam logic [3:0] OFS_CTRL      = 4'h0;                     // parity and pin mode
    localparam logic [3:0] OFS_STATUS    = 4'h4;                     // live state

    // field positions
    localparam int unsigned CTRL_PAR_LSB = 0;                        // parity, two bits
    localparam int unsigned CTRL_MODE_B  = 4;                        // status pin mode
    localparam int unsigned STAT_LINK_B  = 0;                        // link up
    localparam int unsigned STAT_PIN_B   = 1;                        // status pin level
    localparam int unsigned STAT_BUSY_B  = 2;                        // reply in progress

    // reset values and parity limit
    localparam logic [1:0] PARITY_RESET  = 2'h0;                     // no parity
    localparam logic       MODE_RESET    = 1'b0;                     // plain link indication
    localparam logic [1:0] PARITY_MAX    = 2'h2;                     // even is the top code

    // ascii pieces of commands and replies
    localparam logic [7:0]  CH_CR        = 8'h0d;
    localparam logic [7:0]  CH_LF        = 8'h0a;
    localparam logic [7:0]  CH_ZERO      = 8'h30;
    localparam logic [7:0]  CH_ONE       = 8'h31;
    localparam logic [7:0]  CH_TWO       = 8'h32;
    localparam logic [7:0]  CH_COMMA     = 8'h2c;
    localparam logic [7:0]  CH_EQ        = 8'h3d;
    localparam logic [7:0]  CH_PLUS      = 8'h2b;
    localparam logic [15:0] TXT_AT       = 16'h4154;
    localparam logic [63:0] KW_FRAME     = 64'h5541_5254_4d4f_4445; // frame-config keyword
    localparam logic [31:0] KW_PIN       = 32'h5354_5453;           // status-pin keyword
    localparam logic [15:0] TXT_OK       = 16'h4f4b;
    localparam logic [23:0] TXT_ERR      = 24'h455252;

    // reply selection
    typedef enum logic [2:0] {
        RPY_OK,
        RPY_ERR,
        RPY_FRAME_Q,
        RPY_PIN_Q
    } pscp_reply_t;

endpackage

// >>> hw/pscp_stat_pin.sv
// link status pin driver with data-activity blanking
`timescale 1ns/1ns
module pscp_stat_pin #(
    parameter int unsigned IDLE_CYCLES = pscp_pkg::IDLE_CYCLES,
    parameter int unsigned TW          = pscp_pkg::IDLE_TW
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic clkEn,
    input  wire logic pinMode,
    input  wire logic linkUp,
    input  wire logic peerByte,
    output logic      statusPin
);
    import pscp_pkg::*;

    // counter must hold the whole delay
    generate
        if (IDLE_CYCLES < 1 || IDLE_CYCLES > (2 ** TW) - 1) begin : g_bad
            $error("idle delay does not fit counter");
        end
    endgenerate

    localparam logic [TW-1:0] IDLE_LOAD = IDLE_CYCLES[TW-1:0];   // reload value
    localparam logic [TW-1:0] ONE       = {{(TW-1){1'b0}}, 1'b1}; // unit step

    logic [TW-1:0] idle_reg;      // cycles left until pin returns high
    logic [TW-1:0] idle_next;
    logic          pin_reg;       // registered pin level
    logic          pin_next;

    // mode 1 blanks on each byte; a new byte reloads so the quiet time is measured from the last one
    wire blankHit = pinMode && peerByte;          // data seen in mode 1; acted on only while linked
    wire idleDone = (idle_reg == ONE);            // last cycle of the delay

    always_comb begin
        idle_next = idle_reg;
        pin_next  = pin_reg;
        if (!linkUp) begin
            // low while unconnected and after a drop
            idle_next = '0;
            pin_next  = 1'b0;
        end else if (blankHit) begin
            idle_next = IDLE_LOAD;
            pin_next  = 1'b0;
        end else if (idle_reg != '0) begin
            // still counting the quiet interval
            idle_next = idle_reg - ONE;
            pin_next  = idleDone;
        end else begin
            // connected and quiet, or mode 0
            pin_next  = 1'b1;
        end
    end

    // state update, frozen when the clock enable is low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idle_reg <= '0;
            pin_reg  <= 1'b0;
        end else if (clkEn) begin
            idle_reg <= idle_next;
            pin_reg  <= pin_next;
        end
    end

    assign statusPin = pin_reg;

endmodule

// >>> hw/pscp_cmd_top.sv
// text command interpreter for parity and status-pin mode, with avalon register view
`timescale 1ns/1ns
// What this block does
// - frame-config sets parity none, odd, even
// - status-pin mode command sets, queries mode 0/1
// - mode 0: pin high only while linked
// - mode 1: pin low on data, high later
// - lines end CR LF; bare query returns value
module pscp_cmd_top #(
    parameter int unsigned IDLE_CYCLES = pscp_pkg::IDLE_CYCLES
) (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          clkEn,
    input  wire logic [7:0]                    cmdByte,
    input  wire logic                          cmdValid,
    output logic [7:0]                         replyByte,
    output logic                               replyValid,
    input  wire logic                          replyReady,
    input  wire logic                          linkUp,
    input  wire logic                          peerByte,
    output logic                               statusPin,
    output logic [1:0]                         parityMode,
    input  wire logic [3:0]                    avsAddress,
    input  wire logic                          avsRead,
    input  wire logic                          avsWrite,
    input  wire logic [31:0]                   avsWriteData,
    input  wire logic [3:0]                    avsByteEnable,
    output logic [31:0]                        avsReadData,
    output logic                               avsWaitRequest
);
    import pscp_pkg::*;

    localparam int unsigned LW = LINE_BYTES * 8;  // line buffer width
    localparam int unsigned MW = MSG_BYTES * 8;   // reply buffer width
    localparam logic [LEN_W-1:0] LEN_ONE  = 4'h1;
    localparam logic [LEN_W-1:0] LEN_FULL = 4'hf; // overflow marker
    localparam logic [LEN_W-1:0] LEN_AT   = 4'h2;
    localparam logic [LEN_W-1:0] LEN_PQ   = 4'h7;
    localparam logic [LEN_W-1:0] LEN_PS   = 4'h8;
    localparam logic [LEN_W-1:0] LEN_FQ   = 4'hb;
    localparam logic [LEN_W-1:0] LEN_FS   = 4'he;
    localparam logic [4:0]       CNT_ONE  = 5'h01;

    // digit helpers, used for both commands
    function automatic logic isDigitUpTo(input logic [7:0] ch, input logic [7:0] top);
        isDigitUpTo = (ch >= CH_ZERO) && (ch <= top);
    endfunction

    // state
    logic [LW-1:0]    line_reg;     // newest byte in the low lane
    logic [LW-1:0]    line_next;
    logic [LEN_W-1:0] len_reg;      // bytes in the current line
    logic [LEN_W-1:0] len_next;
    logic [1:0]       parity_reg;   // active parity code
    logic [1:0]       parity_next;
    logic             mode_reg;     // status pin mode
    logic             mode_next;
    logic [MW-1:0]    msg_reg;      // reply text, first byte at the top
    logic [MW-1:0]    msg_next;
    logic [4:0]       cnt_reg;      // reply bytes left
    logic [4:0]       cnt_next;
    logic             wait_reg;     // avalon waitrequest
    logic             valid_reg;    // reply valid, kept in step with the byte count
    logic [31:0]      rdata_reg;    // avalon read data
    logic [31:0]      rdata_next;
    logic             pinLevel;     // from the pin driver

    // line handling: CR dropped, LF closes the line
    wire byteIn   = clkEn && cmdValid;
    wire isCr     = (cmdByte == CH_CR);
    wire isLf     = (cmdByte == CH_LF);
    wire busy     = (cnt_reg != 5'h00);
    wire lineEnd  = byteIn && isLf && !busy;  // lines closed while replying are discarded

    // command decode on the closed line
    wire cmdAt    = (len_reg == LEN_AT) && (line_reg[15:0] == TXT_AT);
    wire cmdFrmQ  = (len_reg == LEN_FQ) && (line_reg[87:0] == {TXT_AT, CH_PLUS, KW_FRAME});
    wire cmdFrmS  = (len_reg == LEN_FS) && (line_reg[111:24] == {TXT_AT, CH_PLUS, KW_FRAME})
                    && (line_reg[23:16] == CH_ZERO) && (line_reg[15:8] == CH_COMMA)
                    && isDigitUpTo(line_reg[7:0], CH_TWO);
    wire cmdPinQ  = (len_reg == LEN_PQ) && (line_reg[55:0] == {TXT_AT, CH_PLUS, KW_PIN});
    wire cmdPinS  = (len_reg == LEN_PS) && (line_reg[63:8] == {TXT_AT, CH_PLUS, KW_PIN})
                    && isDigitUpTo(line_reg[7:0], CH_ONE);

    wire [1:0] parDigit = line_reg[1:0];  // '0'..'2' low bits are the code
    wire       modeDigit = line_reg[0];

    // reply choice
    wire pscp_reply_t reply = cmdFrmQ ? RPY_FRAME_Q :
                              cmdPinQ ? RPY_PIN_Q :
                              (cmdAt || cmdFrmS || cmdPinS) ? RPY_OK : RPY_ERR;

    // avalon decode; one wait cycle, then the answer
    wire avsReq    = avsRead || avsWrite;
    wire avsTake   = clkEn && avsReq && wait_reg;
    wire selCtrl   = (avsAddress == OFS_CTRL);
    wire selStat   = (avsAddress == OFS_STATUS);
    // a write lands only at the edge that completes the transfer, when waitrequest is low
    wire ctrlWr    = clkEn && avsWrite && !wait_reg && selCtrl && avsByteEnable[0];
    wire [1:0] busPar = avsWriteData[CTRL_PAR_LSB +: 2];
    wire [31:0] ctrlView = {27'h0, mode_reg, 2'h0, parity_reg};
    wire [31:0] statView = {29'h0, busy, pinLevel, linkUp};

    // line buffer and control values
    always_comb begin
        line_next   = line_reg;
        len_next    = len_reg;
        parity_next = parity_reg;
        mode_next   = mode_reg;
        if (byteIn && isLf) begin
            // start a fresh line after every terminator
            line_next = '0;
            len_next  = '0;
        end else if (byteIn && !isCr) begin
            line_next = {line_reg[LW-9:0], cmdByte};
            len_next  = (len_reg == LEN_FULL) ? LEN_FULL : len_reg + LEN_ONE;
        end
        if (lineEnd && cmdFrmS) begin
            parity_next = parDigit;
        end
        if (lineEnd && cmdPinS) begin
            mode_next = modeDigit;
        end
        // bus write wins over a command closed in the same cycle
        if (ctrlWr) begin
            parity_next = (busPar <= PARITY_MAX) ? busPar : parity_reg;
            mode_next   = avsWriteData[CTRL_MODE_B];
        end
    end

    // reply text builder and streamer
    always_comb begin
        msg_next = msg_reg;
        cnt_next = cnt_reg;
        if (lineEnd) begin
            case (reply)
                RPY_OK: begin
                    msg_next = {CH_PLUS, TXT_OK, CH_CR, CH_LF, 88'h0};
                    cnt_next = 5'h05;
                end
                RPY_FRAME_Q: begin
                    // keyword, equals, fixed 0, comma, parity code
                    msg_next = {CH_PLUS, KW_FRAME, CH_EQ, CH_ZERO, CH_COMMA,
                                CH_ZERO | {6'h0, parity_reg}, CH_CR, CH_LF, 8'h0};
                    cnt_next = 5'h0f;
                end
                RPY_PIN_Q: begin
                    msg_next = {CH_PLUS, KW_PIN, CH_EQ, CH_ZERO | {7'h0, mode_reg},
                                CH_CR, CH_LF, 56'h0};
                    cnt_next = 5'h09;
                end
                default: begin
                    msg_next = {CH_PLUS, TXT_ERR, CH_CR, CH_LF, 80'h0};
                    cnt_next = 5'h06;
                end
            endcase
        end else if (clkEn && busy && replyReady) begin
            // byte taken, move the next one to the top lane
            msg_next = {msg_reg[MW-9:0], 8'h0};
            cnt_next = cnt_reg - CNT_ONE;
        end
    end

    // avalon read data
    assign rdata_next = !avsTake ? rdata_reg :
                        !avsRead ? 32'h0 :
                        selCtrl  ? ctrlView :
                        selStat  ? statView : 32'h0;  // unmapped reads as zero

    // command side registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            line_reg   <= '0;
            len_reg    <= '0;
            parity_reg <= PARITY_RESET;
            mode_reg   <= MODE_RESET;
        end else if (clkEn) begin
            line_reg   <= line_next;
            len_reg    <= len_next;
            parity_reg <= parity_next;
            mode_reg   <= mode_next;
        end
    end

    // reply side registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            msg_reg   <= '0;
            cnt_reg   <= '0;
            valid_reg <= 1'b0;
        end else if (clkEn) begin
            msg_reg   <= msg_next;
            cnt_reg   <= cnt_next;
            valid_reg <= (cnt_next != 5'h00);  // output straight from a flop
        end
    end

    // bus slave registers: waitrequest drops for exactly one cycle per request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
        end else if (clkEn) begin
            wait_reg  <= !avsTake;
            rdata_reg <= rdata_next;
        end
    end

    // status pin behaviour lives in its own module
    pscp_stat_pin #(
        .IDLE_CYCLES (IDLE_CYCLES),
        .TW          (IDLE_TW)
    ) u_pin (
        .clock     (clock),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .pinMode   (mode_reg),
        .linkUp    (linkUp),
        .peerByte  (peerByte),
        .statusPin (pinLevel)
    );

    assign statusPin      = pinLevel;
    assign parityMode     = parity_reg;
    assign replyByte      = msg_reg[MW-1:MW-8];
    assign replyValid     = valid_reg;
    assign avsReadData    = rdata_reg;
    assign avsWaitRequest = wait_reg;

endmodule

// >>> bench/pscp_cmd_assertions.sv
// port-level checks for the command block
`timescale 1ns/1ns
module pscp_cmd_assertions
    import pscp_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = pscp_pkg::IDLE_CYCLES
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        clkEn,
    input wire logic [7:0]  cmdByte,
    input wire logic        cmdValid,
    input wire logic [7:0]  replyByte,
    input wire logic        replyValid,
    input wire logic        replyReady,
    input wire logic        linkUp,
    input wire logic        peerByte,
    input wire logic        statusPin,
    input wire logic [1:0]  parityMode,
    input wire logic [3:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0]  avsByteEnable,
    input wire logic        avsWaitRequest
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [31:0] quietCnt_reg; // cycles since last link byte, saturating
    // starts saturated, so a pin rising just after reset is not blamed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            quietCnt_reg <= IDLE_CYCLES;
        end else if (clkEn) begin
            quietCnt_reg <= peerByte ? 32'h0 : quietCnt_reg + {31'h0, quietCnt_reg < IDLE_CYCLES};
        end
    end
    a_wait_one_cycle: assert property (
        (avsRead || avsWrite) && avsWaitRequest && clkEn |=> !avsWaitRequest ##1 avsWaitRequest)
        else $error("waitrequest not low for exactly one cycle");
    a_parity_legal: assert property (parityMode != 2'h3)
        else $error("parity holds the unused code");
    a_parity_write: assert property (
        avsWrite && !avsWaitRequest && clkEn && avsAddress == OFS_CTRL && avsByteEnable[0]
        && avsWriteData[1:0] <= PARITY_MAX |=> {30'h0, parityMode} == ($past(avsWriteData) & 32'h3))
        else $error("parity not taken from the control write");
    a_link_drop: assert property (!linkUp && clkEn |=> !statusPin)
        else $error("status pin high without a link");
    a_pin_fall_cause: assert property ($fell(statusPin) |-> !$past(linkUp) || $past(peerByte))
        else $error("status pin fell without cause");
    a_pin_rise_cause: assert property (
        $rose(statusPin) |-> $past(linkUp) && (quietCnt_reg >= IDLE_CYCLES || !$past(linkUp, 2)))
        else $error("status pin rose before the quiet delay");
    a_reply_start: assert property (
        cmdValid && clkEn && cmdByte == CH_LF && !replyValid |=> replyValid && replyByte == CH_PLUS)
        else $error("no reply after line end");
    a_reply_hold: assert property (replyValid && !replyReady && clkEn |=> replyValid && $stable(replyByte))
        else $error("reply byte changed while stalled");
    a_reply_end: assert property (replyValid && replyReady && clkEn && replyByte == CH_LF |=> !replyValid)
        else $error("reply continued after line feed");
endmodule
bind pscp_cmd_top pscp_cmd_assertions #(.IDLE_CYCLES(IDLE_CYCLES)) i_pscp_cmd_assertions (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .cmdByte(cmdByte), .cmdValid(cmdValid),
    .replyByte(replyByte), .replyValid(replyValid), .replyReady(replyReady), .linkUp(linkUp),
    .peerByte(peerByte), .statusPin(statusPin), .parityMode(parityMode), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsWaitRequest(avsWaitRequest));

// >>> bench/pscp_host_model.sv
// host controller model: sends command lines and collects replies
`timescale 1ns/1ns
module pscp_host_model
    import pscp_pkg::*;
(
    input  wire logic       clock,
    output logic [7:0]      cmdByte,
    output logic            cmdValid,
    input  wire logic [7:0] replyByte,
    input  wire logic       replyValid,
    output logic            replyReady
);
    initial begin
        cmdByte = 8'h00;
        cmdValid = 1'b0;
        replyReady = 1'b0;
    end
    // one pulse per byte; idle data shows the inverse so stale bytes never look valid
    task automatic putByte(input logic [7:0] b);
        @(posedge clock);
        cmdByte <= b;
        cmdValid <= 1'b1;
        @(posedge clock);
        cmdValid <= 1'b0;
        cmdByte <= ~b;
    endtask
    // whole line then whole reply; slow stalls every other cycle
    task automatic sendLine(input string line, input bit slow, output logic [127:0] rep, output bit ok);
        ok = 1'b0;
        rep = '0;
        for (int i = 0; i < line.len(); i++) begin
            putByte(line[i]);
        end
        putByte(CH_CR);
        putByte(CH_LF);
        for (int n = 0; n < 100 && !ok; n++) begin
            replyReady <= slow ? ~replyReady : 1'b1;
            @(posedge clock);
            if (replyValid && replyReady) begin
                rep = {rep[119:0], replyByte};
                ok = replyByte == CH_LF;
            end
        end
        replyReady <= 1'b0;
    endtask
endmodule

// >>> bench/pscp_cmd_top_tb.sv
// self-checking bench for the parity and status-pin command block
`timescale 1ns/1ns
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin nErrors++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pscp_cmd_top_tb;
    import pscp_pkg::*;
    localparam int unsigned IDLE = 20; // short quiet delay keeps the run brief
    typedef struct {int kw; string arg; string rep; logic [1:0] par;} pscp_row_t;
    logic         clock = 1'b0, rst_n = 1'b0, linkUp = 1'b0, peerByte = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    logic         clkEn = 1'b1;
    logic         cmdValid, replyValid, replyReady, statusPin, avsWaitRequest;
    logic [3:0]   avsAddress = 4'h0, avsByteEnable = 4'hf;
    logic [7:0]   cmdByte, replyByte;
    logic [1:0]   parityMode;
    logic [31:0]  avsWriteData = 32'h0, avsReadData, rd, n;
    logic [127:0] rep;
    int           nErrors = 0, checksDone = 0;
    bit           ok;
    string        kws[3], ln, ex;
    // keyword index, argument, reply tail, parity afterwards
    pscp_row_t    rows[13] = '{'{0, "", "OK", 2'h0}, '{2, "", "=0", 2'h0}, '{1, "", "=0,0", 2'h0},
        '{1, "0,1", "OK", 2'h1}, '{1, "", "=0,1", 2'h1}, '{1, "0,2", "OK", 2'h2}, '{1, "0,3", "ERR", 2'h2},
        '{1, "0,0", "OK", 2'h0}, '{2, "1", "OK", 2'h0}, '{2, "", "=1", 2'h0}, '{2, "2", "ERR", 2'h0},
        '{0, "+Q", "ERR", 2'h0}, '{1, "0,00000", "ERR", 2'h0}};
    always #25 clock = ~clock;
    pscp_cmd_top #(.IDLE_CYCLES(IDLE)) i_pscp_cmd_top (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
        .cmdByte(cmdByte), .cmdValid(cmdValid), .replyByte(replyByte), .replyValid(replyValid),
        .replyReady(replyReady), .linkUp(linkUp), .peerByte(peerByte), .statusPin(statusPin),
        .parityMode(parityMode), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest));
    pscp_host_model i_pscp_host_model (.clock(clock), .cmdByte(cmdByte), .cmdValid(cmdValid),
        .replyByte(replyByte), .replyValid(replyValid), .replyReady(replyReady));
    function automatic logic [127:0] s2v(input string s);
        s2v = '0;
        foreach (s[i]) s2v = {s2v[119:0], s[i]};
    endfunction
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        avsRead <= !w;
        avsWrite <= w;
        avsAddress <= a;
        avsWriteData <= d;
        avsByteEnable <= be;
        for (int k = 0; k < 50; k++) begin
            @(posedge clock);
            if (avsWaitRequest === 1'b0) begin
                rd = avsReadData;
                avsRead <= 1'b0;
                avsWrite <= 1'b0;
                return;
            end
        end
        nErrors++;
        printVerdict();
    endtask
    task automatic pulse(input int gap);
        @(posedge clock) peerByte <= 1'b1;
        @(posedge clock) peerByte <= 1'b0;
        repeat (gap) @(posedge clock);
    endtask
    // remote master: two idle cycles, then the link is up
    task automatic peerConnect();
        repeat (2) @(posedge clock);
        @(posedge clock) linkUp <= 1'b1;
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        nErrors++;
        printVerdict();
    end
    initial begin
        kws[1] = $sformatf("%s", KW_FRAME);
        kws[2] = $sformatf("%s", KW_PIN);
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        `CHK({parityMode, statusPin, avsWaitRequest}, 4'h1)
        bus(0, OFS_CTRL, 0, 4'hf);
        `CHK(rd, 32'h0)
        foreach (rows[i]) begin
            ln = rows[i].kw != 0 ? {"AT+", kws[rows[i].kw], rows[i].arg} : {"AT", rows[i].arg};
            ex = rows[i].rep[0] == "=" ? {"+", kws[rows[i].kw], rows[i].rep, "\r\n"} : {"+", rows[i].rep, "\r\n"};
            i_pscp_host_model.sendLine(ln, i[0], rep, ok);
            if (!ok) begin
                nErrors++;
                printVerdict();
            end
            `CHK(rep, s2v(ex))
            `CHK(parityMode, rows[i].par)
            $display("command row %0d done", i);
        end
        bus(1, OFS_CTRL, 32'h12, 4'hf);
        @(posedge clock); // the write lands at the completing edge
        `CHK(parityMode, 2'h2)
        bus(1, OFS_CTRL, 32'h03, 4'hf);
        bus(1, OFS_CTRL, 32'h11, 4'he);
        bus(0, OFS_CTRL, 0, 4'hf);
        `CHK(rd, 32'h02)
        bus(0, 4'h8, 0, 4'hf);
        `CHK(rd, 32'h0)
        $display("register test done");
        peerConnect();
        pulse(3);
        bus(0, OFS_STATUS, 0, 4'hf);
        `CHK(rd, 32'h3)
        clkEn <= 1'b0; // frozen: the drop must not reach the pin yet
        linkUp <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(statusPin, 1'b1)
        clkEn <= 1'b1;
        pulse(1);
        `CHK(statusPin, 1'b0)
        $display("pin mode 0 test done");
        bus(1, OFS_CTRL, 32'h10, 4'hf);
        peerConnect();
        pulse(10);
        `CHK(statusPin, 1'b0)
        pulse(0);
        for (n = 1; n < 100 && statusPin !== 1'b1; n++) @(posedge clock);
        // pulse returns at the edge that takes the byte; the loop sees the pin one edge after it rises
        `CHK(n, IDLE + 2)
        linkUp <= 1'b0;
        pulse(1);
        `CHK(statusPin, 1'b0)
        $display("pin mode 1 test done");
        bus(1, OFS_CTRL, 32'h11, 4'hf);
        rst_n <= 1'b0;
        @(posedge clock);
        `CHK({parityMode, avsWaitRequest}, 3'h1)
        rst_n <= 1'b1;
        bus(0, OFS_CTRL, 0, 4'hf);
        `CHK(rd, 32'h0)
        $display("second reset test done");
        printVerdict();
    end
endmodule
